// *** hdl/pslf_pkg.sv ***
// pslf_pkg: constants, types and register map of the power module status and fault supervisor
// assumes a single 25 MHz crystal-referenced clock shared in step by every module of the shelf
package pslf_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned BLINK_HZ      = 1;
  localparam int unsigned BACKUP_SEC    = 90;
  localparam int unsigned FAN_PERSIST_S = 5;
  localparam int unsigned OCP_PERSIST_S = 2;
  localparam int unsigned OTP_PERSIST_S = 2;
  localparam int unsigned SEC_CYCLES    = CLK_HZ;
  localparam int unsigned HALF_BLINK_CYCLES = CLK_HZ / (2 * BLINK_HZ);

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FAULT  = 8'h08;
  localparam logic [7:0] ADDR_NVREC  = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_REPLUG_BIT = 0;
  localparam int unsigned CTRL_NVACK_BIT  = 1;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // fault vector positions
  localparam int unsigned F_FAN   = 0;
  localparam int unsigned F_OCP   = 1;
  localparam int unsigned F_OTP   = 2;
  localparam int unsigned F_OVP   = 3;
  localparam int unsigned F_GEN   = 4;
  localparam int unsigned F_REG12 = 5;
  localparam int unsigned F_ACIN  = 6;
  localparam int unsigned F_AUX54 = 7;
  localparam int unsigned F_CAN   = 8;
  localparam int unsigned F_BOOST = 9;
  localparam int unsigned F_CHG   = 10;
  localparam int unsigned NFAULT  = 11;

  // indicator colour
  typedef enum logic [1:0] {
    PSLF_LED_OFF    = 2'b00,
    PSLF_LED_YELLOW = 2'b01,
    PSLF_LED_GREEN  = 2'b10
  } pslf_color_t;

  // battery backup unit status lines
  typedef struct packed {
    logic present;
    logic volt_ok;
    logic fail_n;
    logic sleep_insert;
  } pslf_bbu_t;

  // wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } pslf_wb_req_t;

  // converter enable outputs
  typedef struct packed {
    logic main_12v;
    logic aux_54v;
    logic charger;
    logic boost;
  } pslf_en_t;

endpackage

// *** hdl/pslf_persist.sv ***
// pslf_persist: holds a fault condition for a set time before reporting it
// assumes cond is already synchronised to clk
`timescale 1ns/1ns
`default_nettype none
module pslf_persist #(
  parameter int unsigned CYCLES = 50_000_000
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // condition in, qualified out
  input  wire logic cond,
  output var  logic hit
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        hit;
  } pslf_pst_t;

  pslf_pst_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!cond) begin
      s_nxt.cnt = 32'h0;
      s_nxt.hit = 1'b0;
    end else if (s_r.cnt >= CYCLES - 1) begin
      s_nxt.hit = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hit = s_r.hit;
endmodule
`default_nettype wire

// *** hdl/pslf_blink.sv ***
// pslf_blink: 1 Hz blink phase and backup timeout, both counted on the shared crystal clock
// assumes every module's clock and backup entry line up so phases match
`timescale 1ns/1ns
`default_nettype none
module pslf_blink #(
  parameter int unsigned HALF_CYCLES = 12_500_000,
  parameter int unsigned TIMEOUT_S   = 90,
  parameter int unsigned SEC_CYC     = 25_000_000
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // backup phase
  input  wire logic active,
  output var  logic phase,
  output var  logic expired
);
  typedef struct packed {
    logic [31:0] half;
    logic [31:0] sec;
    logic [7:0]  secs;
    logic        phase;
    logic        expired;
  } pslf_blk_t;

  pslf_blk_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!active) begin
      s_nxt = '0;
      s_nxt.phase = 1'b1;
    end else begin
      if (s_r.half >= HALF_CYCLES - 1) begin
        s_nxt.half  = 32'h0;
        s_nxt.phase = ~s_r.phase;
      end else begin
        s_nxt.half = s_r.half + 32'h1;
      end
      if (s_r.sec >= SEC_CYC - 1) begin
        s_nxt.sec = 32'h0;
        if (s_r.secs < 8'(TIMEOUT_S)) begin
          s_nxt.secs = s_r.secs + 8'h1;
        end
      end else begin
        s_nxt.sec = s_r.sec + 32'h1;
      end
      s_nxt.expired = (s_r.secs >= 8'(TIMEOUT_S));
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign phase   = s_r.phase;
  assign expired = s_r.expired;
endmodule
`default_nettype wire

// *** hdl/pslf_top.sv ***
// pslf_top: power module status indicators, fault latching and converter latch-off
// assumes raw status pins are asynchronous; wishbone master on ref_clk; nonvolatile write done by firmware
//
// Function
// - solid yellow: AC valid, output regulated, battery absent, low, failing or asleep
// - solid green: AC valid, output regulated, battery installed at 32 V or more
// - backup: yellow blinks at 1 Hz, backup bounded by 90 second timeout
// - blink counters run from shared crystal clock so modules blink in step
// - red indicator solid on module failures including fan, dark otherwise
// - main 12 V failure latches off auxiliary, charger and boost converters
// - aux, boost, charger or CAN failure lights red, latches fail, 12 V stays
// - boost or charger fault survives AC removal and restore
// - fan, current, voltage, temp, AC, general, regulation faults: 12 V off, replug clears
// - aux 54 V or CAN failure: 12 V kept, red stays after replug, restart allowed
// - boost or charger fault: red stays after replug, restart allowed, recorded nonvolatile
// - power-good and fault indicators never lit together
// - entering backup never clears an active fault indication
// - failure during boost operation latches fault indication permanently
// - fan failure latches off after 5 seconds persistence
// - overcurrent latches off after 2 seconds persistence
// - overtemperature latches off after 2 seconds persistence
// - 12 V regulation loss, overvoltage, general failure latch off immediately
// - same latch-off rules govern boost and charger converters
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pslf_top #(
  parameter int unsigned SEC_CYC     = pslf_pkg::SEC_CYCLES,
  parameter int unsigned HALF_CYCLES = pslf_pkg::HALF_BLINK_CYCLES
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  // wishbone slave
  input  wire pslf_pkg::pslf_wb_req_t wb_req,
  output var  logic [31:0]           wb_dat_o,
  output var  logic                  wb_ack_o,
  // power status pins
  input  wire logic                  ac_valid,
  input  wire logic                  out_reg_ok,
  input  wire logic                  backup_active,
  input  wire logic                  module_seated,
  input  wire pslf_pkg::pslf_bbu_t   battery_backup_unit,
  // raw fault detectors
  input  wire logic [pslf_pkg::NFAULT-1:0] fault_raw,
  // indicators
  output var  pslf_pkg::pslf_color_t power_good_backup_indicator,
  output var  logic                  fail_led,
  output var  logic                  fail_latched,
  // converter enables and nonvolatile record request
  output var  pslf_pkg::pslf_en_t    conv_en,
  output var  logic                  nv_write_req
);
  localparam int unsigned NS = pslf_pkg::NFAULT + 5;

  // fault classes
  localparam logic [pslf_pkg::NFAULT-1:0] OFF_MASK = 11'h07F;
  localparam logic [pslf_pkg::NFAULT-1:0] KEEP_MASK = 11'h780;
  localparam logic [pslf_pkg::NFAULT-1:0] NV_MASK = 11'h600;

  // two-flop synchronisers for every pin
  logic [NS-1:0] sy1_r, sy2_r;
  logic [NS-1:0] pins;
  assign pins = {ac_valid, out_reg_ok, backup_active, module_seated,
                 battery_backup_unit.present & battery_backup_unit.volt_ok &
                 battery_backup_unit.fail_n & ~battery_backup_unit.sleep_insert,
                 fault_raw};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= pins;
      sy2_r <= sy1_r;
    end
  end

  logic ac_s, reg_s, bkp_s, seat_s, bbu_ok_s;
  logic [pslf_pkg::NFAULT-1:0] flt_s;
  assign {ac_s, reg_s, bkp_s, seat_s, bbu_ok_s, flt_s} = sy2_r;

  // persistence qualifiers; immediate faults pass straight through
  logic fan_hit, ocp_hit, otp_hit;
  logic [pslf_pkg::NFAULT-1:0] qual;

  pslf_persist #(.CYCLES(SEC_CYC * pslf_pkg::FAN_PERSIST_S)) u_fan (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .cond    (flt_s[pslf_pkg::F_FAN]),
    .hit     (fan_hit)
  );
  pslf_persist #(.CYCLES(SEC_CYC * pslf_pkg::OCP_PERSIST_S)) u_ocp (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .cond    (flt_s[pslf_pkg::F_OCP]),
    .hit     (ocp_hit)
  );
  pslf_persist #(.CYCLES(SEC_CYC * pslf_pkg::OTP_PERSIST_S)) u_otp (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .cond    (flt_s[pslf_pkg::F_OTP]),
    .hit     (otp_hit)
  );

  always_comb begin
    qual = flt_s;
    qual[pslf_pkg::F_FAN] = fan_hit;
    qual[pslf_pkg::F_OCP] = ocp_hit;
    qual[pslf_pkg::F_OTP] = otp_hit;
  end

  // blink and timeout
  logic blink_ph, bkp_expired;
  pslf_blink #(
    .HALF_CYCLES (HALF_CYCLES),
    .TIMEOUT_S   (pslf_pkg::BACKUP_SEC),
    .SEC_CYC     (SEC_CYC)
  ) u_blink (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .active  (bkp_s),
    .phase   (blink_ph),
    .expired (bkp_expired)
  );

  // fault latch, replug and bus state; indicator and enable flops are kept below
  typedef struct packed {
    logic [pslf_pkg::NFAULT-1:0] latch;
    logic                        perm;
    logic                        seat_d;
    logic                        nv_pend;
    logic                        replug_sw;
    logic [31:0]                 rdat;
    logic                        ack;
  } pslf_st_t;

  pslf_st_t s_r, s_nxt;

  logic replug_ev;
  logic wb_hit;
  logic [pslf_pkg::NFAULT-1:0] clear_mask;
  logic main_off, any_fault, pg_on;

  assign wb_hit    = wb_req.cyc & wb_req.stb & ~s_r.ack;
  assign replug_ev = (seat_s & ~s_r.seat_d) | s_r.replug_sw;
  // AC loss alone never clears; only replug clears shutdown-class faults
  assign clear_mask = replug_ev ? OFF_MASK : '0;

  always_comb begin
    s_nxt = s_r;
    s_nxt.seat_d    = seat_s;
    s_nxt.replug_sw = 1'b0;
    s_nxt.ack       = wb_hit;
    // set wins over clear; backup entry never touches the latch
    s_nxt.latch = (s_r.latch & ~clear_mask) | qual;
    if (~ac_s & ~bkp_s) begin
      s_nxt.latch[pslf_pkg::F_ACIN] = s_r.latch[pslf_pkg::F_ACIN] | s_r.seat_d;
    end
    if (bkp_s & (|qual)) begin
      s_nxt.perm = 1'b1;
    end
    if (|(qual & NV_MASK)) begin
      s_nxt.nv_pend = 1'b1;
    end
    // a write lands at the edge where the master sees ack, while its request still stands
    if (s_r.ack & wb_req.cyc & wb_req.stb & wb_req.we & wb_req.sel[0] &
        (wb_req.adr == pslf_pkg::ADDR_CTRL)) begin
      s_nxt.replug_sw = wb_req.dat[pslf_pkg::CTRL_REPLUG_BIT];
      if (wb_req.dat[pslf_pkg::CTRL_NVACK_BIT] & ~(|(qual & NV_MASK))) begin
        s_nxt.nv_pend = 1'b0;
      end
    end
    s_nxt.rdat = 32'h0;
    if (wb_hit & ~wb_req.we) begin
      unique case (wb_req.adr)
        pslf_pkg::ADDR_CTRL:   s_nxt.rdat = 32'h0;
        pslf_pkg::ADDR_STATUS: s_nxt.rdat = {24'h0, bkp_expired, blink_ph, s_r.perm,
                                             any_fault, pg_on, ac_s, reg_s, bbu_ok_s};
        pslf_pkg::ADDR_FAULT:  s_nxt.rdat = {21'h0, s_r.latch};
        pslf_pkg::ADDR_NVREC:  s_nxt.rdat = {31'h0, s_r.nv_pend};
        default:               s_nxt.rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // decisions
  always_comb begin
    any_fault = (|s_r.latch) | s_r.perm;
    main_off  = |(s_r.latch & OFF_MASK);
    pg_on     = ac_s & reg_s & ~any_fault;
  end

  // outputs from flops where data
  pslf_pkg::pslf_color_t col_r, col_nxt;
  pslf_pkg::pslf_en_t    en_r, en_nxt;
  logic                  fail_r;

  always_comb begin
    col_nxt = pslf_pkg::PSLF_LED_OFF;
    if (!any_fault) begin
      if (bkp_s & ~bkp_expired) begin
        col_nxt = blink_ph ? pslf_pkg::PSLF_LED_YELLOW : pslf_pkg::PSLF_LED_OFF;
      end else if (pg_on & bbu_ok_s) begin
        col_nxt = pslf_pkg::PSLF_LED_GREEN;
      end else if (pg_on) begin
        col_nxt = pslf_pkg::PSLF_LED_YELLOW;
      end
    end
    en_nxt.main_12v = ~main_off;
    // secondary converters follow the main rail and their own latches
    en_nxt.aux_54v = ~main_off & ~s_r.latch[pslf_pkg::F_AUX54];
    en_nxt.charger = ~main_off & ~s_r.latch[pslf_pkg::F_CHG];
    en_nxt.boost   = ~main_off & ~s_r.latch[pslf_pkg::F_BOOST] & ~bkp_expired;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      col_r  <= pslf_pkg::PSLF_LED_OFF;
      en_r   <= '0;
      fail_r <= 1'b0;
    end else begin
      col_r  <= col_nxt;
      en_r   <= en_nxt;
      fail_r <= any_fault;
    end
  end

  assign power_good_backup_indicator = col_r;
  assign fail_led     = fail_r;
  assign fail_latched = fail_r;
  assign conv_en      = en_r;
  assign nv_write_req = s_r.nv_pend;
  assign wb_dat_o     = s_r.rdat;
  assign wb_ack_o     = s_r.ack;
endmodule
`default_nettype wire

// *** sim/pslf_checker.sv ***
// pslf_checker: port checks of indicators, latch-off and bus answer
// assumes binding into pslf_top with the same shortened counts
`timescale 1ns/1ns
`default_nettype none
module pslf_checker #(
  parameter int unsigned SEC_CYC     = 25_000_000,
  parameter int unsigned HALF_CYCLES = 12_500_000
) (
  // clock and reset
  input wire logic                        ref_clk,
  input wire logic                        nrst,
  // bus
  input wire pslf_pkg::pslf_wb_req_t      wb_req,
  input wire logic                        wb_ack_o,
  // status and raw faults
  input wire logic                        ac_valid,
  input wire logic                        backup_active,
  input wire logic [pslf_pkg::NFAULT-1:0] fault_raw,
  // indicators and enables
  input wire pslf_pkg::pslf_color_t       power_good_backup_indicator,
  input wire logic                        fail_led,
  input wire pslf_pkg::pslf_en_t          conv_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // raw runs include the sync delay, so the thresholds are lower bounds
  int unsigned           fan_r, oc_r, ot_r, bk_r, run_r;
  pslf_pkg::pslf_color_t pg_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {fan_r, oc_r, ot_r, bk_r, run_r} <= '0;
      pg_r <= pslf_pkg::PSLF_LED_OFF;
    end else begin
      fan_r <= fault_raw[pslf_pkg::F_FAN] ? fan_r + 1 : 0;
      oc_r  <= fault_raw[pslf_pkg::F_OCP] ? oc_r + 1 : 0;
      ot_r  <= fault_raw[pslf_pkg::F_OTP] ? ot_r + 1 : 0;
      bk_r  <= backup_active ? bk_r + 1 : 0;
      run_r <= (power_good_backup_indicator != pg_r) ? 1 : run_r + 1;
      pg_r  <= power_good_backup_indicator;
    end
  end
  sequence s_take; wb_req.cyc && wb_req.stb && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_bus; s_take |=> s_ans; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not one pulse");
  property p_excl; !(fail_led && power_good_backup_indicator != pslf_pkg::PSLF_LED_OFF); endproperty
  a_excl: assert property (p_excl) else $error("both indicators lit");
  property p_sec; !conv_en.main_12v |-> !(conv_en.aux_54v || conv_en.charger || conv_en.boost); endproperty
  a_sec: assert property (p_sec) else $error("secondary on with main off");
  property p_cause;
    $fell(conv_en.main_12v) |-> fault_raw[6:3] != 4'h0 || (!ac_valid && !backup_active)
      || fan_r >= 5 * SEC_CYC || oc_r >= 2 * SEC_CYC || ot_r >= 2 * SEC_CYC;
  endproperty
  a_cause: assert property (p_cause) else $error("main off without due cause");
  property p_fan; fan_r == 5 * SEC_CYC + 8 |-> !conv_en.main_12v; endproperty
  a_fan: assert property (p_fan) else $error("fan fault not latched");
  property p_oc; oc_r == 2 * SEC_CYC + 8 |-> !conv_en.main_12v; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent not latched");
  property p_ot; ot_r == 2 * SEC_CYC + 8 |-> !conv_en.main_12v; endproperty
  a_ot: assert property (p_ot) else $error("overtemperature not latched");
  property p_imm; (fault_raw[5:3] != 3'h0) [*6] |-> !conv_en.main_12v; endproperty
  a_imm: assert property (p_imm) else $error("immediate fault not latched");
  property p_keep; fail_led && $rose(backup_active) |=> fail_led [*8]; endproperty
  a_keep: assert property (p_keep) else $error("red cleared by backup");
  property p_blink;
    power_good_backup_indicator != pg_r && bk_r > HALF_CYCLES + 8 && !fail_led && fault_raw == '0
      && bk_r < pslf_pkg::BACKUP_SEC * SEC_CYC - HALF_CYCLES |-> run_r == HALF_CYCLES;
  endproperty
  a_blink: assert property (p_blink) else $error("blink half period wrong");
endmodule
bind pslf_top pslf_checker #(.SEC_CYC(SEC_CYC), .HALF_CYCLES(HALF_CYCLES)) chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .wb_req(wb_req), .wb_ack_o(wb_ack_o), .ac_valid(ac_valid),
  .backup_active(backup_active), .fault_raw(fault_raw), .fail_led(fail_led), .conv_en(conv_en),
  .power_good_backup_indicator(power_good_backup_indicator));
`default_nettype wire

// *** sim/pslf_bbu_model.sv ***
// pslf_bbu_model: battery unit status lines seen by the module
// assumes the bench picks a condition; lines follow one edge later
`timescale 1ns/1ns
`default_nettype none
module pslf_bbu_model (
  // clock
  input  wire logic                ref_clk,
  // condition: 0 absent, 1 good, 2 low, 3 failing, 4 asleep
  input  wire logic [2:0]          mode,
  // status lines
  output var  pslf_pkg::pslf_bbu_t bbu
);
  // an absent unit leaves its lines pulled low
  always_ff @(posedge ref_clk) begin
    bbu.present      <= (mode != 3'h0);
    bbu.volt_ok      <= (mode != 3'h0) && (mode != 3'h2);
    bbu.fail_n       <= (mode != 3'h0) && (mode != 3'h3);
    bbu.sleep_insert <= (mode == 3'h4);
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// tb_top: directed bench of the status and fault supervisor
// assumes shortened second and blink counts; classic wishbone cycles
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int unsigned SC = 20;
  localparam int unsigned HC = 10;
  logic                        ref_clk = 1'b0;
  logic                        nrst = 1'b0;
  pslf_pkg::pslf_wb_req_t      wb_req = '0;
  logic [31:0]                 wb_dat_o, rd;
  logic                        wb_ack_o, fail_led, fail_latched, nv_write_req;
  logic                        ac_valid = 1'b1;
  logic                        out_reg_ok = 1'b1;
  logic                        backup_active = 1'b0;
  logic                        module_seated = 1'b1;
  logic [2:0]                  mode = 3'h1;
  logic [pslf_pkg::NFAULT-1:0] fault_raw = '0;
  pslf_pkg::pslf_bbu_t         bbu;
  pslf_pkg::pslf_color_t       pg;
  pslf_pkg::pslf_en_t          en;
  int                          fails = 0;
  int                          cmp_count = 0;
  int unsigned                 per [7] = '{5, 2, 2, 0, 0, 0, 0};
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  pslf_top #(.SEC_CYC(SC), .HALF_CYCLES(HC)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ac_valid(ac_valid), .out_reg_ok(out_reg_ok),
    .backup_active(backup_active), .module_seated(module_seated), .battery_backup_unit(bbu),
    .fault_raw(fault_raw), .power_good_backup_indicator(pg), .fail_led(fail_led),
    .fail_latched(fail_latched), .conv_en(en), .nv_write_req(nv_write_req));
  pslf_bbu_model bbu_u (.ref_clk(ref_clk), .mode(mode), .bbu(bbu));
  task finish_test;
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // settle at the falling edge so every sample sees the landed updates
  task w(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_req <= '0;
    if (k >= 20) begin
      fails++;
      finish_test();
    end
  endtask
  task setf(input int i, input logic v);
    @(posedge ref_clk);
    fault_raw[i] <= v;
  endtask
  task rst;
    @(posedge ref_clk);
    nrst <= 1'b0;
    w(12);
    @(posedge ref_clk);
    nrst <= 1'b1;
    w(6);
  endtask
  task replug;
    @(posedge ref_clk);
    module_seated <= 1'b0;
    w(3);
    @(posedge ref_clk);
    module_seated <= 1'b1;
    w(6);
  endtask
  initial begin
    int i;
    w(12);
    @(posedge ref_clk);
    nrst <= 1'b1;
    w(8);
    chk("pg", pg, pslf_pkg::PSLF_LED_GREEN);
    for (i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      mode <= i[2:0];
      w(6);
      chk("pg", pg, i == 1 ? pslf_pkg::PSLF_LED_GREEN : pslf_pkg::PSLF_LED_YELLOW);
    end
    @(posedge ref_clk);
    out_reg_ok <= 1'b0;
    mode <= 3'h1;
    w(6);
    chk("pg", pg, pslf_pkg::PSLF_LED_OFF);
    @(posedge ref_clk);
    out_reg_ok <= 1'b1;
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    wb(1'b0, 8'h10, '0);
    chk("unmapped", rd, 32'h0);
    wb(1'b0, pslf_pkg::ADDR_CTRL, '0);
    chk("ctrl", rd, pslf_pkg::CTRL_RESET);
    // shutdown class; the fan run is broken once so its count must restart
    for (i = 0; i < 7; i++) begin
      setf(i, 1'b1);
      if (i == 0) begin
        w(4 * SC);
        setf(0, 1'b0);
        w(3);
        setf(0, 1'b1);
      end
      if (per[i] > 0) begin
        w(per[i] * SC - 5);
        chk("main early", en.main_12v, 1'b1);
      end
      w(15);
      chk("main", en.main_12v, 1'b0);
      chk("secondary", {en.aux_54v, en.charger, en.boost}, 3'h0);
      chk("red", fail_led, 1'b1);
      wb(1'b0, pslf_pkg::ADDR_FAULT, '0);
      chk("fault", rd, 32'h1 << i);
      setf(i, 1'b0);
      // let the released cause pass the synchroniser and persistence stage before clearing
      w(4);
      if (i[0])
        replug();
      else
        wb(1'b1, pslf_pkg::ADDR_CTRL, 32'h1);
      w(6);
      chk("main back", en.main_12v, 1'b1);
      chk("red off", fail_led, 1'b0);
    end
    // converter faults that keep 12 V on
    for (i = 7; i < 11; i++) begin
      rst();
      setf(i, 1'b1);
      w(8);
      chk("main", en.main_12v, 1'b1);
      chk("red latch", {fail_led, fail_latched}, 2'h3);
      chk("nv", nv_write_req, i > 8);
      setf(i, 1'b0);
      replug();
      chk("red kept", fail_led, 1'b1);
      chk("restart", en.main_12v, 1'b1);
      if (i > 8) begin
        @(posedge ref_clk);
        ac_valid <= 1'b0;
        w(6);
        @(posedge ref_clk);
        ac_valid <= 1'b1;
        replug();
        chk("red after ac", fail_led, 1'b1);
        wb(1'b1, pslf_pkg::ADDR_CTRL, 32'h2);
        w(3);
        chk("nv ack", nv_write_req, 1'b0);
      end
    end
    // backup: blink, timeout, then a fault in backup stays for good
    rst();
    @(posedge ref_clk);
    backup_active <= 1'b1;
    ac_valid <= 1'b0;
    w(5);
    chk("blink on", pg, pslf_pkg::PSLF_LED_YELLOW);
    w(HC);
    chk("blink off", pg, pslf_pkg::PSLF_LED_OFF);
    w(pslf_pkg::BACKUP_SEC * SC);
    wb(1'b0, pslf_pkg::ADDR_STATUS, '0);
    chk("expired", rd[7], 1'b1);
    chk("boost", en.boost, 1'b0);
    setf(pslf_pkg::F_GEN, 1'b1);
    w(6);
    chk("red", fail_led, 1'b1);
    setf(pslf_pkg::F_GEN, 1'b0);
    @(posedge ref_clk);
    backup_active <= 1'b0;
    ac_valid <= 1'b1;
    replug();
    chk("red held", fail_led, 1'b1);
    wb(1'b0, pslf_pkg::ADDR_STATUS, '0);
    chk("permanent", rd[5], 1'b1);
    @(posedge ref_clk);
    backup_active <= 1'b1;
    w(10);
    chk("red in backup", fail_led, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
